// ### status_one_pkg.sv
// shared constants and types for the status register one block
package status_one_pkg;

  // command opcodes
  localparam logic [7:0] OP_WRITE_REGS = 8'h01;
  localparam logic [7:0] OP_CLR_LATCH  = 8'h04;
  localparam logic [7:0] OP_READ_ONE   = 8'h05;
  localparam logic [7:0] OP_SET_LATCH  = 8'h06;
  localparam logic [7:0] OP_CLR_STATUS = 8'h30;
  localparam logic [7:0] OP_SET_LATCH_V = 8'h50;
  localparam logic [7:0] OP_READ_ANY   = 8'h65;
  localparam logic [7:0] OP_RESET_ARM  = 8'h66;
  localparam logic [7:0] OP_WRITE_ANY  = 8'h71;
  localparam logic [7:0] OP_RESET_GO   = 8'h99;

  // field positions inside status_one
  localparam int LOCK_POS   = 7;
  localparam int ORIGIN_POS = 6;
  localparam int BP_HI_POS  = 5;
  localparam int BP_LO_POS  = 2;
  localparam int LATCH_POS  = 1;
  localparam int BUSY_POS   = 0;

  // shipped contents of the non-volatile copy
  localparam logic [7:0] NV_SHIP = 8'h00;

  // write-any-register targets
  localparam logic [23:0] ADDR_NV   = 24'h000000;
  localparam logic [23:0] ADDR_LIVE = 24'h000001;

  // frame lengths in bytes, opcode included
  localparam logic [2:0] LEN_CMD       = 3'h1;
  localparam logic [2:0] LEN_WRITE_REG = 3'h2;
  localparam logic [2:0] LEN_WRITE_ANY = 3'h5;

  // synchroniser depth behind the frame-end edge detect
  localparam int SYNC_LEN = 3;

  typedef struct packed {
    logic       lock;
    logic       origin;
    logic [3:0] bp;
    logic       latch;
    logic       busy;
  } status_type;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [31:0] args;
    logic [2:0]  nbytes;
  } frame_type;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_PROGRAM,
    KIND_ERASE,
    KIND_REGISTER
  } op_kind_type;

endpackage

// ### status_one_reg.sv
// status register one: serial command front end and live/default copies
`timescale 1ns/1ps
module status_one_reg #(
  parameter int ADDR_W      = 24,
  parameter int BLOCK_SHIFT = 16
) (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic                        sclk,
  input  wire logic                        cs_n,
  input  wire logic                        si,
  output logic                             so_out,
  output logic                             so_oe_n,
  input  wire logic                        wp_n,
  input  wire logic                        quad_peripheral_mode,
  input  wire logic                        quad_io_mode,
  input  wire logic                        array_req,
  input  status_one_pkg::op_kind_type      array_kind,
  input  wire logic [ADDR_W-1:0]           array_addr,
  input  wire logic                        suspend_req,
  input  wire logic                        op_done,
  input  wire logic                        program_error,
  input  wire logic                        erase_error,
  output logic                             op_start,
  output status_one_pkg::op_kind_type      op_kind,
  output logic                             suspend_go,
  output logic [1:0]                       error_flags,
  output logic [7:0]                       status_one_live,
  output logic [7:0]                       status_one_nonvolatile,
  output logic                             prot_en,
  output logic [ADDR_W-1:0]                prot_lo,
  output logic [ADDR_W-1:0]                prot_hi
);

  if (ADDR_W <= BLOCK_SHIFT || ADDR_W > 31 || BLOCK_SHIFT < 1) begin : g_chk
    $error("status_one_reg: bad ADDR_W or BLOCK_SHIFT");
  end

  // ---------------- link domain (sclk) ----------------
  logic                     first_q;
  logic [2:0]               bit_q;
  logic [2:0]               bit_d;
  logic [6:0]               sh_q;
  logic [6:0]               sh_d;
  status_one_pkg::frame_type fr_q;
  status_one_pkg::frame_type fr_d;
  logic [7:0]               byte_in;
  logic [2:0]               nb_cur;
  logic                     tx_q;
  logic                     tx_d;
  logic                     oe_n_q;
  logic                     oe_n_d;
  logic [7:0]               snap_q;
  logic [7:0]               snap_d;

  always_comb begin
    byte_in = {sh_q, si};
    nb_cur  = first_q ? 3'h0 : fr_q.nbytes;
    bit_d   = bit_q + 3'h1;
    sh_d    = byte_in[6:0];
    fr_d    = fr_q;
    if (first_q) begin
      fr_d.nbytes = 3'h0;
      fr_d.args   = 32'h0;
      fr_d.opcode = 8'h00;
    end
    if (bit_q == 3'h7) begin
      // bytes past the longest frame are dropped, not shifted in
      if (nb_cur == 3'h0) begin
        fr_d.opcode = byte_in;
      end else if (nb_cur != status_one_pkg::LEN_WRITE_ANY) begin
        fr_d.args = {fr_d.args[23:0], byte_in};
      end
      if (nb_cur != status_one_pkg::LEN_WRITE_ANY) begin
        fr_d.nbytes = nb_cur + 3'h1;
      end
    end
  end

  // frame regs are not cleared by cs_n: the core reads them after the
  // frame ends, so they must hold until the next frame's first edge
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_q <= 1'b1;
      bit_q   <= 3'h0;
    end else begin
      first_q <= 1'b0;
      bit_q   <= bit_d;
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      sh_q <= sh_d;
      fr_q <= fr_d;
    end
  end

  // read data shifts out on the falling edge, msb first, repeating
  always_comb begin
    tx_d   = tx_q;
    oe_n_d = oe_n_q;
    if (!first_q && fr_q.nbytes != 3'h0 &&
        fr_q.opcode == status_one_pkg::OP_READ_ONE) begin
      tx_d   = snap_q[3'h7 - bit_q];
      oe_n_d = 1'b0;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_q   <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      tx_q   <= tx_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign so_out  = tx_q;
  assign so_oe_n = oe_n_q;

  // ---------------- core domain (clk_sys) ----------------
  logic [status_one_pkg::SYNC_LEN-1:0] cs_sync_q;
  logic [1:0]                           wp_sync_q;
  status_one_pkg::status_type           nv_q;
  status_one_pkg::status_type           nv_d;
  status_one_pkg::status_type           live_q;
  status_one_pkg::status_type           live_d;
  status_one_pkg::op_kind_type          kind_q;
  status_one_pkg::op_kind_type          kind_d;
  logic [7:0]                           pend_q;
  logic [7:0]                           pend_d;
  logic [1:0]                           err_q;
  logic [1:0]                           err_d;
  logic                                 armed_q;
  logic                                 armed_d;
  logic                                 start_q;
  logic                                 start_d;
  logic                                 susp_q;
  logic                                 susp_d;
  logic                                 pen_q;
  logic                                 pen_d;
  logic [ADDR_W-1:0]                    plo_q;
  logic [ADDR_W-1:0]                    plo_d;
  logic [ADDR_W-1:0]                    phi_q;
  logic [ADDR_W-1:0]                    phi_d;
  logic                                 frame_end;
  logic                                 wp_level;
  logic                                 locked;
  logic                                 cmd_ok;
  logic                                 wr_ok;
  logic                                 in_prot;
  logic [ADDR_W:0]                      size;

  // bytes shielded for a protect code; codes with bp-1+BLOCK_SHIFT >= ADDR_W saturate to whole array
  function automatic logic [ADDR_W:0] prot_size(input logic [3:0] bp);
    int sh;
    sh = int'(bp) - 1 + BLOCK_SHIFT;
    if (bp == 4'h0) begin
      prot_size = '0;
    end else if (sh >= ADDR_W) begin
      prot_size = {1'b1, {ADDR_W{1'b0}}};
    end else begin
      prot_size = (ADDR_W+1)'(1) << sh;
    end
  endfunction

  function automatic logic is_busy_cmd(input logic [7:0] op);
    is_busy_cmd = (op == status_one_pkg::OP_READ_ONE)
               || (op == status_one_pkg::OP_READ_ANY)
               || (op == status_one_pkg::OP_CLR_STATUS)
               || (op == status_one_pkg::OP_RESET_ARM)
               || (op == status_one_pkg::OP_RESET_GO);
  endfunction

  always_comb begin
    frame_end = cs_sync_q[1] & ~cs_sync_q[2];
    wp_level  = wp_sync_q[1] | quad_peripheral_mode | quad_io_mode;
    locked    = live_q.lock & ~wp_level;
    cmd_ok    = ~live_q.busy | is_busy_cmd(fr_q.opcode);
    wr_ok     = live_q.latch & ~locked;
    in_prot   = pen_q && array_addr >= plo_q && array_addr <= phi_q;
    size      = prot_size(live_q.bp);
    nv_d      = nv_q;
    live_d    = live_q;
    kind_d    = kind_q;
    pend_d    = pend_q;
    err_d     = err_q;
    armed_d   = armed_q;
    start_d   = 1'b0;
    susp_d    = 1'b0;
    snap_d    = cs_sync_q[1] ? live_q : snap_q;
    pen_d     = size != '0;
    if (live_q.origin) begin
      plo_d = '0;
      phi_d = ADDR_W'(size - (ADDR_W+1)'(1));
    end else begin
      plo_d = ADDR_W'({1'b1, {ADDR_W{1'b0}}} - size);
      phi_d = {ADDR_W{1'b1}};
    end
    if (frame_end && cmd_ok && fr_q.nbytes != 3'h0) begin
      armed_d = fr_q.opcode == status_one_pkg::OP_RESET_ARM;
      case (fr_q.opcode)
        status_one_pkg::OP_SET_LATCH,
        status_one_pkg::OP_SET_LATCH_V: begin
          live_d.latch = 1'b1;
        end
        status_one_pkg::OP_CLR_LATCH: begin
          live_d.latch = 1'b0;
        end
        status_one_pkg::OP_CLR_STATUS: begin
          err_d        = 2'h0;
          live_d.latch = 1'b0;
          if (err_q != 2'h0) begin
            live_d.busy = 1'b0;
            kind_d      = status_one_pkg::KIND_NONE;
          end
        end
        status_one_pkg::OP_RESET_GO: begin
          if (armed_q) begin
            live_d = nv_q;
            kind_d = status_one_pkg::KIND_NONE;
            err_d  = 2'h0;
          end
        end
        status_one_pkg::OP_WRITE_REGS: begin
          if (wr_ok && fr_q.nbytes == status_one_pkg::LEN_WRITE_REG) begin
            pend_d      = {fr_q.args[7:2], nv_q.latch, nv_q.busy};
            kind_d      = status_one_pkg::KIND_REGISTER;
            live_d.busy = 1'b1;
            start_d     = 1'b1;
          end
        end
        status_one_pkg::OP_WRITE_ANY: begin
          if (wr_ok && fr_q.nbytes == status_one_pkg::LEN_WRITE_ANY) begin
            if (fr_q.args[31:8] == status_one_pkg::ADDR_NV) begin
              pend_d      = {fr_q.args[7:2], nv_q.latch, nv_q.busy};
              kind_d      = status_one_pkg::KIND_REGISTER;
              live_d.busy = 1'b1;
              start_d     = 1'b1;
            end else if (fr_q.args[31:8] == status_one_pkg::ADDR_LIVE) begin
              // volatile write completes at once: busy untouched, latch cleared
              live_d.lock   = fr_q.args[status_one_pkg::LOCK_POS];
              live_d.origin = fr_q.args[status_one_pkg::ORIGIN_POS];
              live_d.bp     = fr_q.args[status_one_pkg::BP_HI_POS:
                                        status_one_pkg::BP_LO_POS];
              live_d.latch  = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (array_req && !live_q.busy && live_q.latch && !in_prot &&
                 (array_kind == status_one_pkg::KIND_PROGRAM ||
                  array_kind == status_one_pkg::KIND_ERASE)) begin
      kind_d      = array_kind;
      live_d.busy = 1'b1;
      start_d     = 1'b1;
    end
    if (suspend_req && err_q == 2'h0 &&
        (kind_q == status_one_pkg::KIND_PROGRAM ||
         kind_q == status_one_pkg::KIND_ERASE)) begin
      susp_d = 1'b1;
    end
    // completion last so an error set wins over a same-cycle clear
    if (op_done && kind_q != status_one_pkg::KIND_NONE && err_q == 2'h0) begin
      if (program_error || erase_error) begin
        err_d = err_d | {erase_error, program_error};
      end else begin
        live_d.busy  = 1'b0;
        live_d.latch = 1'b0;
        kind_d       = status_one_pkg::KIND_NONE;
        if (kind_q == status_one_pkg::KIND_REGISTER) begin
          nv_d          = pend_q;
          live_d.lock   = pend_q[status_one_pkg::LOCK_POS];
          live_d.origin = pend_q[status_one_pkg::ORIGIN_POS];
          live_d.bp     = pend_q[status_one_pkg::BP_HI_POS:
                                 status_one_pkg::BP_LO_POS];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    // level crossings: first stage feeds only the second
    cs_sync_q <= {cs_sync_q[1:0], cs_n};
    wp_sync_q <= {wp_sync_q[0], wp_n};
    if (!resetn) begin
      nv_q    <= status_one_pkg::NV_SHIP;
      live_q  <= status_one_pkg::NV_SHIP;
      kind_q  <= status_one_pkg::KIND_NONE;
      pend_q  <= 8'h00;
      err_q   <= 2'h0;
      armed_q <= 1'b0;
      start_q <= 1'b0;
      susp_q  <= 1'b0;
      snap_q  <= 8'h00;
      pen_q   <= 1'b0;
      plo_q   <= '0;
      phi_q   <= '0;
    end else begin
      nv_q    <= nv_d;
      live_q  <= live_d;
      kind_q  <= kind_d;
      pend_q  <= pend_d;
      err_q   <= err_d;
      armed_q <= armed_d;
      start_q <= start_d;
      susp_q  <= susp_d;
      snap_q  <= snap_d;
      pen_q   <= pen_d;
      plo_q   <= plo_d;
      phi_q   <= phi_d;
    end
  end

  assign op_start               = start_q;
  assign op_kind                = kind_q;
  assign suspend_go             = susp_q;
  assign error_flags            = err_q;
  assign status_one_live        = live_q;
  assign status_one_nonvolatile = nv_q;
  assign prot_en                = pen_q;
  assign prot_lo                = plo_q;
  assign prot_hi                = phi_q;

endmodule // status_one_reg

// ### status_one_reg_sva.sv
// concurrent checks on the status register one block ports
`timescale 1ns/1ps
module status_one_reg_sva (
  input wire logic                   clk_sys,
  input wire logic                   resetn,
  input wire logic                   array_req,
  input wire logic                   suspend_req,
  input wire logic                   op_done,
  input wire logic                   program_error,
  input wire logic                   erase_error,
  input wire logic                   op_start,
  input status_one_pkg::op_kind_type op_kind,
  input wire logic                   suspend_go,
  input wire logic [1:0]             error_flags,
  input wire logic [7:0]             status_one_live,
  input wire logic [7:0]             status_one_nonvolatile
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_start_needs_latch: assert property (
    op_start |-> $past(status_one_live[1]))
    else $error("op started without latch");
  a_start_sets_busy: assert property (
    op_start |-> status_one_live[0] && op_kind != status_one_pkg::KIND_NONE)
    else $error("op started but not busy");
  a_busy_blocks_start: assert property (
    status_one_live[0] && array_req |=> !op_start)
    else $error("op started while busy");
  a_done_clears_latch: assert property (
    op_done && op_kind != status_one_pkg::KIND_NONE && !program_error
    && !erase_error && error_flags == 2'b00
    |=> status_one_live[1:0] == 2'b00)
    else $error("clean finish left latch or busy");
  a_error_keeps_busy: assert property (
    op_done && (program_error || erase_error) |=> status_one_live[0]
    && error_flags != 2'b00 && $stable(status_one_live[1]))
    else $error("error did not hold busy");
  a_suspend_needs_op: assert property (
    suspend_go |-> $past(suspend_req) && $past(op_kind) inside
    {status_one_pkg::KIND_PROGRAM, status_one_pkg::KIND_ERASE})
    else $error("suspend accepted without array op");
  a_nv_low_zero: assert property (
    status_one_nonvolatile[1:0] == 2'b00)
    else $error("read-only default bits changed");
  a_reset_loads_live: assert property (
    $rose(resetn) |-> status_one_live == 8'h00 ##1 !op_start)
    else $error("live copy wrong after reset");
endmodule // status_one_reg_sva

bind status_one_reg status_one_reg_sva chk (
  .clk_sys(clk_sys), .resetn(resetn), .array_req(array_req),
  .suspend_req(suspend_req), .op_done(op_done),
  .program_error(program_error), .erase_error(erase_error),
  .op_start(op_start), .op_kind(op_kind), .suspend_go(suspend_go),
  .error_flags(error_flags), .status_one_live(status_one_live),
  .status_one_nonvolatile(status_one_nonvolatile));

// ### spi_host_model.sv
// serial host model that sends command frames at the link
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  logic [7:0] rd;
  event       got;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // mode 0, bytes left aligned; clock only runs inside a frame
  task automatic frame(input logic [39:0] b, input int n, input bit rd_en);
    #7 cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      si = b[39-i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    // an undriven output must never pass as data
    for (int i = 7; rd_en && i >= 0; i--) begin
      #16 sclk = 1'b1;
      rd[i] = so_oe_n ? 1'bx : so_out;
      #16 sclk = 1'b0;
    end
    if (rd_en)
      -> got;
    si = ~si;
    #16 cs_n = 1'b1;
    #48;
  endtask
endmodule // spi_host_model

// ### status_one_reg_tb.sv
// self-checking bench for the status register one block
`timescale 1ns/1ps
module status_one_reg_tb;
  logic        clk_sys, resetn, sclk, cs_n, si, so_out, so_oe_n, wp_n;
  logic        quad_peripheral_mode, quad_io_mode, array_req, suspend_req;
  logic        op_done, program_error, erase_error, op_start, suspend_go;
  logic        prot_en;
  logic [1:0]  error_flags;
  logic [7:0]  status_one_live, status_one_nonvolatile;
  logic [23:0] array_addr, prot_lo, prot_hi, live;
  logic [23:0] rq[$];
  logic [23:0] kq[$];
  int          failures, cmp_count;
  status_one_pkg::op_kind_type array_kind, op_kind;

  assign live = {16'h0, status_one_live};

  status_one_reg dut (
    .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .si(si), .so_out(so_out), .so_oe_n(so_oe_n), .wp_n(wp_n),
    .quad_peripheral_mode(quad_peripheral_mode),
    .quad_io_mode(quad_io_mode), .array_req(array_req),
    .array_kind(array_kind), .array_addr(array_addr),
    .suspend_req(suspend_req), .op_done(op_done),
    .program_error(program_error), .erase_error(erase_error),
    .op_start(op_start), .op_kind(op_kind), .suspend_go(suspend_go),
    .error_flags(error_flags), .status_one_live(status_one_live),
    .status_one_nonvolatile(status_one_nonvolatile), .prot_en(prot_en),
    .prot_lo(prot_lo), .prot_hi(prot_hi));

  spi_host_model host (
    .sclk(sclk), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n));

  task automatic check(string n, logic [23:0] s, logic [23:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic cmd(logic [7:0] op);
    host.frame({op, 32'h0}, 1, 1'b0);
    cyc(8);
  endtask

  task automatic rdsr(logic [23:0] e);
    rq.push_back(e);
    host.frame({8'h05, 32'h0}, 1, 1'b1);
    cyc(4);
  endtask

  task automatic wany(logic [23:0] a, logic [7:0] d);
    cmd(8'h06);
    host.frame({8'h71, a, d}, 5, 1'b0);
    cyc(8);
  endtask

  task automatic arr(status_one_pkg::op_kind_type k, logic [23:0] a, bit go);
    if (go)
      kq.push_back({22'h0, k});
    array_req  <= 1'b1;
    array_kind <= k;
    array_addr <= a;
    @(posedge clk_sys);
    array_req <= 1'b0;
    cyc(2);
  endtask

  task automatic done(logic pe, logic ee);
    op_done       <= 1'b1;
    program_error <= pe;
    erase_error   <= ee;
    @(posedge clk_sys);
    op_done <= 1'b0;
    cyc(2);
  endtask

  task automatic sus(logic e);
    suspend_req <= 1'b1;
    @(posedge clk_sys);
    suspend_req <= 1'b0;
    #1 check("suspend", {23'h0, suspend_go}, {23'h0, e});
    @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // results are matched in issue order as they appear
  initial forever begin
    @(host.got);
    check("status", {16'h0, host.rd}, rq.pop_front());
  end

  always @(posedge clk_sys)
    if (op_start === 1'b1)
      check("kind", {22'h0, op_kind}, kq.pop_front());

  // whole run is far below this span
  initial begin
    #100000;
    failures++;
    final_report();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    {resetn, quad_peripheral_mode, quad_io_mode, array_req} = 4'h0;
    {suspend_req, op_done, program_error, erase_error} = 4'h0;
    wp_n = 1'b1;
    array_kind = status_one_pkg::KIND_NONE;
    array_addr = 24'h0;
    void'($urandom(32'h9b5a2a22));
    cyc(10);
    resetn <= 1'b1;
    cyc(4);
    check("live", live, 24'h00);
    check("nv", {16'h0, status_one_nonvolatile}, 24'h00);
    rdsr(24'h00);
    cmd(8'h06);
    rdsr(24'h02);
    cmd(8'h04);
    check("live", live, 24'h00);
    arr(status_one_pkg::KIND_PROGRAM, 24'($urandom), 1'b0);
    cmd(8'h50);
    check("live", live, 24'h02);
    arr(status_one_pkg::KIND_PROGRAM, 24'($urandom), 1'b1);
    check("live", live, 24'h03);
    cmd(8'h04);
    check("live", live, 24'h03);
    sus(1'b1);
    done(1'b0, 1'b0);
    check("live", live, 24'h00);
    sus(1'b0);
    cmd(8'h06);
    arr(status_one_pkg::KIND_ERASE, 24'($urandom), 1'b1);
    done(1'b0, 1'b1);
    check("live", live, 24'h03);
    check("errors", {22'h0, error_flags}, 24'h02);
    arr(status_one_pkg::KIND_PROGRAM, 24'($urandom), 1'b0);
    cmd(8'h30);
    check("live", live, 24'h00);
    check("errors", {22'h0, error_flags}, 24'h00);
    wany(status_one_pkg::ADDR_LIVE, 8'h44);
    check("fields", live & 24'hfc, 24'h44);
    cyc(2);
    check("prot en", {23'h0, prot_en}, 24'h000001);
    check("low end", prot_lo, 24'h000000);
    check("high end", prot_hi, 24'h00ffff);
    cmd(8'h06);
    arr(status_one_pkg::KIND_PROGRAM, 24'($urandom) & 24'h00ffff, 1'b0);
    check("live", live, 24'h46);
    wany(status_one_pkg::ADDR_LIVE, 8'h84);
    check("low end", prot_lo, 24'hff0000);
    check("high end", prot_hi, 24'hffffff);
    wp_n <= 1'b0;
    wany(status_one_pkg::ADDR_LIVE, 8'h00);
    check("live", live, 24'h86);
    quad_io_mode <= 1'b1;
    wany(status_one_pkg::ADDR_LIVE, 8'h00);
    check("fields", live & 24'hfc, 24'h00);
    quad_io_mode <= 1'b0;
    wany(status_one_pkg::ADDR_LIVE, 8'h80);
    check("live", live, 24'h80);
    quad_peripheral_mode <= 1'b1;
    wany(status_one_pkg::ADDR_LIVE, 8'h00);
    check("fields", live & 24'hfc, 24'h00);
    quad_peripheral_mode <= 1'b0;
    kq.push_back({22'h0, status_one_pkg::KIND_REGISTER});
    wany(status_one_pkg::ADDR_NV, 8'h4b);
    check("busy", live & 24'h01, 24'h01);
    done(1'b0, 1'b0);
    check("nv", {16'h0, status_one_nonvolatile}, 24'h48);
    check("live", live, 24'h48);
    kq.push_back({22'h0, status_one_pkg::KIND_REGISTER});
    cmd(8'h06);
    host.frame({8'h01, 8'h27, 24'h0}, 2, 1'b0);
    cyc(8);
    check("live", live, 24'h4b);
    done(1'b0, 1'b0);
    check("nv", {16'h0, status_one_nonvolatile}, 24'h24);
    check("live", live, 24'h24);
    wany(status_one_pkg::ADDR_LIVE, 8'h80);
    cmd(8'h06);
    cmd(8'h66);
    cmd(8'h99);
    rdsr(24'h24);
    cmd(8'h06);
    resetn <= 1'b0;
    cyc(4);
    resetn <= 1'b1;
    cyc(2);
    check("live", live, 24'h00);
    final_report();
  end
endmodule // status_one_reg_tb
